// >>> hw/rdcu_defines.svh
// Offsets, field positions, reset values and timing counts of the direct command unit
`ifndef RDCU_DEFINES_SVH
`define RDCU_DEFINES_SVH

// Register byte offsets on the APB bus
`define RDCU_OFF_CMD 12'h000
`define RDCU_OFF_CTRL 12'h004
`define RDCU_OFF_STAT 12'h008
`define RDCU_OFF_RXWAIT 12'h00c
`define RDCU_OFF_TXLEN 12'h010
`define RDCU_OFF_RSSI 12'h014
`define RDCU_OFF_FIFO 12'h018

// Command word fields
`define RDCU_CMD_FLAG_BIT 7
`define RDCU_CMD_CODE_MSB 4

// Command codes
`define RDCU_C_IDLE 5'h00
`define RDCU_C_INIT 5'h03
`define RDCU_C_FIFO_RST 5'h0f
`define RDCU_C_TX 5'h10
`define RDCU_C_TX_CRC 5'h11
`define RDCU_C_DTX 5'h12
`define RDCU_C_DTX_CRC 5'h13
`define RDCU_C_SLOT 5'h14
`define RDCU_C_RX_BLOCK 5'h16
`define RDCU_C_RX_EN 5'h17
`define RDCU_C_TEST_INT 5'h18
`define RDCU_C_TEST_EXT 5'h19
`define RDCU_C_GAIN 5'h1a

// Control register fields
`define RDCU_CTRL_VIC_BIT 0
`define RDCU_CTRL_RXON_BIT 1
`define RDCU_CTRL_RFON_BIT 2

// Reset values
`define RDCU_GAIN_RST 2'h0
`define RDCU_RXWAIT_RST 8'h00

// Gain adjust timing
`define RDCU_WIN_US 100
`define RDCU_CLK_MHZ 250
`define RDCU_WIN_CYC (`RDCU_WIN_US * `RDCU_CLK_MHZ)
`define RDCU_GAIN_STEP_DB 5
`define RDCU_GAIN_MAX_DB 15
`define RDCU_GAIN_STEPS (`RDCU_GAIN_MAX_DB / `RDCU_GAIN_STEP_DB)
`define RDCU_EDGE_LIMIT 2
// Wait time unit in cycles per count
`define RDCU_RXWAIT_UNIT 4

`endif

// >>> hw/rdcu_fifo_mem.sv
// Small memory holding transmit payload bytes, registered read data
`timescale 1ns/1ps
`default_nettype none
module rdcu_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 12,
  parameter int AW = 4
) (
  input wire logic mclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  // Storage array
  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if ((1 << AW) < DEPTH) begin
      $error("rdcu_fifo_mem: AW too small for DEPTH");
    end
  end

  // Write port
  always_ff @(posedge mclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge mclk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// >>> hw/rdcu_pkg.sv
// Types of the direct command unit
package rdcu_pkg;
  // Action sequencer states
  typedef enum logic [2:0] {
    RDCU_IDLE,
    RDCU_TX_ARM,
    RDCU_TX_RUN,
    RDCU_RX_WAIT,
    RDCU_GAIN_RUN,
    RDCU_RSSI_RUN
  } rdcu_state_t;
endpackage

// >>> hw/rdcu_top.sv
// Direct command decoder and action sequencer with APB register access
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rdcu_defines.svh"

// Operation
// R1: Decode idle, soft init, FIFO reset
// R2: Decode four transmit commands with/without CRC
// R3: Next slot only with vicinity protocol
// R4: Decode receiver block/enable, tests, gain adjust
// R5: Host sets flag bit, code in 4:0
// R6: FIFO reset clears data, status, collision
// R7: Host: command, then length, then payload
// R8: Immediate transmit starts on first byte
// R9: CRC appended only for CRC variants
// R10: Delayed transmit waits for timer
// R11: Next slot sends protocol-chosen marker
// R12: Host adjusts gain only when quiet
// R13: Count edges per 100us, raise threshold
// R14: 5 dB per step, 15 dB maximum
// R15: Gain returns to maximum on reset
// R16: Host runs external test, receiver only
// R17: External test stores 3-bit RSSI code
// R18: Receiver enabled before either RF test
// R19: Internal test reports RSSI codes 1..7
// R20: Block receiver holds decoder in reset
// R21: Release on enable command or TX end
// R22: Nonzero wait delays release after TX
// R23: Unknown codes change nothing
module rdcu_top #(
  parameter int WIN_CYC = `RDCU_WIN_CYC,
  parameter int DEPTH = 12
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_en,
  input wire logic tx_timer_fire,
  input wire logic tx_ready,
  input wire logic rx_digital,
  input wire logic [2:0] rssi_level,
  input wire logic [6:0] collision_pos,
  output logic tx_start,
  output logic tx_crc,
  output logic tx_slot,
  output logic tx_byte_valid,
  output logic [7:0] tx_byte,
  output logic rx_dec_rst,
  output logic [1:0] gain_step,
  output logic soft_init,
  output logic [6:0] coll_pos
);
  localparam int AW = 4;
  localparam int WCW = $clog2(WIN_CYC + 1);

  initial begin
    if (DEPTH < 2 || DEPTH > 16) begin
      $error("rdcu_top: DEPTH must be 2..16");
    end
    if (WIN_CYC < 1) begin
      $error("rdcu_top: WIN_CYC must be positive");
    end
  end

  // Decode of a command code into "known"
  function automatic logic code_known(input logic [4:0] c);
    unique case (c)
      `RDCU_C_IDLE, `RDCU_C_INIT, `RDCU_C_FIFO_RST, `RDCU_C_TX, `RDCU_C_TX_CRC,
      `RDCU_C_DTX, `RDCU_C_DTX_CRC, `RDCU_C_SLOT, `RDCU_C_RX_BLOCK, `RDCU_C_RX_EN,
      `RDCU_C_TEST_INT, `RDCU_C_TEST_EXT, `RDCU_C_GAIN: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  endfunction

  // Decode of transmit family commands
  function automatic logic code_is_tx(input logic [4:0] c);
    code_is_tx = (c >= `RDCU_C_TX) && (c <= `RDCU_C_DTX_CRC);
  endfunction

  // APB access strobes
  logic acc;
  logic wr;
  assign acc = psel && penable && ce;
  assign wr = acc && pwrite;

  // Command write decode
  logic cmd_wr;
  logic [4:0] cmd_code;
  logic cmd_go;
  assign cmd_wr = wr && (paddr == `RDCU_OFF_CMD);
  assign cmd_code = pwdata[`RDCU_CMD_CODE_MSB:0];
  // Only words with the flag set are commands [R5]
  assign cmd_go = cmd_wr && pwdata[`RDCU_CMD_FLAG_BIT] && code_known(cmd_code); // [R23]

  // Software init acts like a reset for the state below [R1]
  logic init_go;
  logic fifo_rst_go;
  logic hard_clr;
  assign init_go = cmd_go && (cmd_code == `RDCU_C_INIT); // [R1]
  assign fifo_rst_go = cmd_go && (cmd_code == `RDCU_C_FIFO_RST); // [R1]
  assign hard_clr = init_go || !chip_en;

  // Registers
  logic [2:0] ctrl_q;
  logic [7:0] rxwait_q;
  logic [15:0] txlen_q;
  logic [2:0] rssi_q;
  logic crc_q;
  logic delayed_q;
  rdcu_pkg::rdcu_state_t state_q;

  // Control and configuration registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= 3'h0;
      rxwait_q <= `RDCU_RXWAIT_RST;
      txlen_q <= 16'h0000;
    end else if (ce) begin
      if (hard_clr) begin
        ctrl_q <= 3'h0;
        rxwait_q <= `RDCU_RXWAIT_RST;
        txlen_q <= 16'h0000;
      end else if (wr && paddr == `RDCU_OFF_CTRL) begin
        ctrl_q <= pwdata[2:0];
      end else if (wr && paddr == `RDCU_OFF_RXWAIT) begin
        rxwait_q <= pwdata[7:0];
      end else if (wr && paddr == `RDCU_OFF_TXLEN) begin
        txlen_q <= pwdata[15:0];
      end
    end
  end

  // FIFO pointers and count
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic ovf_q;
  logic fifo_wr;
  logic fifo_rd;
  logic [7:0] mem_rdata;
  assign fifo_wr = wr && (paddr == `RDCU_OFF_FIFO) && (cnt_q < (AW+1)'(DEPTH));
  assign fifo_rd = (state_q == rdcu_pkg::RDCU_TX_RUN) && tx_ready && (cnt_q != '0)
    && !tx_byte_valid;

  // FIFO bookkeeping, cleared by FIFO reset [R6]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else if (ce) begin
      if (hard_clr || fifo_rst_go) begin
        wptr_q <= '0; // [R6]
        rptr_q <= '0;
        cnt_q <= '0;
        ovf_q <= 1'b0;
      end else begin
        if (fifo_wr) begin
          wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
        end
        if (fifo_rd) begin
          rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
        end
        cnt_q <= cnt_q + (AW+1)'(fifo_wr) - (AW+1)'(fifo_rd);
        if (wr && paddr == `RDCU_OFF_FIFO && !fifo_wr) begin
          ovf_q <= 1'b1;
        end
      end
    end
  end

  // Payload storage
  rdcu_fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .mclk(mclk),
    .ce(ce),
    .we(fifo_wr),
    .waddr(wptr_q),
    .wdata(pwdata[7:0]),
    .raddr(rptr_q),
    .rdata(mem_rdata)
  );

  // Gain adjust window counter and edge counter
  logic [WCW-1:0] win_q;
  logic [1:0] edges_q;
  logic rx_prev_q;
  // Receive wait counter, wide enough for the largest wait times the unit
  logic [9:0] wait_q;
  logic rx_edge;
  logic win_end;
  assign rx_edge = rx_digital ^ rx_prev_q;
  assign win_end = (win_q == WCW'(WIN_CYC - 1));

  // Previous receiver sample for edge detection
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_prev_q <= 1'b0;
    end else if (ce) begin
      rx_prev_q <= rx_digital;
    end
  end

  // Sequencer of actions
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= rdcu_pkg::RDCU_IDLE;
      crc_q <= 1'b0;
      delayed_q <= 1'b0;
      win_q <= '0;
      edges_q <= '0;
      wait_q <= '0;
    end else if (ce) begin
      if (hard_clr) begin
        state_q <= rdcu_pkg::RDCU_IDLE;
        crc_q <= 1'b0;
        delayed_q <= 1'b0;
      end else if (cmd_go && code_is_tx(cmd_code)) begin
        state_q <= rdcu_pkg::RDCU_TX_ARM; // [R2]
        crc_q <= cmd_code[0]; // [R9]
        delayed_q <= cmd_code[1]; // [R10]
      end else if (cmd_go && cmd_code == `RDCU_C_GAIN) begin
        state_q <= rdcu_pkg::RDCU_GAIN_RUN; // [R4]
        win_q <= '0;
        edges_q <= '0;
      end else if (cmd_go && (cmd_code == `RDCU_C_TEST_INT
                              || cmd_code == `RDCU_C_TEST_EXT)) begin
        state_q <= rdcu_pkg::RDCU_RSSI_RUN; // [R4]
      end else begin
        unique case (state_q)
          rdcu_pkg::RDCU_IDLE: begin
          end
          rdcu_pkg::RDCU_TX_ARM: begin
            // Immediate start on first byte, delayed start on timer [R8] [R10]
            if (delayed_q ? tx_timer_fire : (cnt_q != '0)) begin
              state_q <= rdcu_pkg::RDCU_TX_RUN;
            end
          end
          rdcu_pkg::RDCU_TX_RUN: begin
            // Transmission ends when the FIFO is drained
            if (cnt_q == '0 && !tx_byte_valid && tx_ready) begin
              state_q <= rdcu_pkg::RDCU_RX_WAIT;
              wait_q <= 10'(rxwait_q) * 10'(`RDCU_RXWAIT_UNIT); // [R22]
            end
          end
          rdcu_pkg::RDCU_RX_WAIT: begin
            if (wait_q == '0) begin
              state_q <= rdcu_pkg::RDCU_IDLE;
            end else begin
              wait_q <= wait_q - 1'b1;
            end
          end
          rdcu_pkg::RDCU_GAIN_RUN: begin
            // Windowed edge count [R13]
            win_q <= win_end ? '0 : win_q + 1'b1;
            if (win_end) begin
              edges_q <= '0;
              if (edges_q < 2'(`RDCU_EDGE_LIMIT) || gain_step == 2'(`RDCU_GAIN_STEPS)) begin
                state_q <= rdcu_pkg::RDCU_IDLE; // [R13] [R14]
              end
            end else if (rx_edge && edges_q != 2'h3) begin
              edges_q <= edges_q + 1'b1;
            end
          end
          rdcu_pkg::RDCU_RSSI_RUN: begin
            state_q <= rdcu_pkg::RDCU_IDLE;
          end
        endcase
      end
    end
  end

  // Gain step: one 5 dB step per noisy window, limit 15 dB [R14] [R15]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gain_step <= `RDCU_GAIN_RST;
    end else if (ce) begin
      if (hard_clr) begin
        gain_step <= `RDCU_GAIN_RST; // [R15]
      end else if (state_q == rdcu_pkg::RDCU_GAIN_RUN && win_end
                   && edges_q > 2'(`RDCU_EDGE_LIMIT)
                   && gain_step != 2'(`RDCU_GAIN_STEPS)) begin
        gain_step <= gain_step + 1'b1; // [R13] [R14]
      end
    end
  end

  // RSSI capture on either RF test, only while the receiver decoder is out of reset [R17] [R19] [R18]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rssi_q <= 3'h0;
    end else if (ce) begin
      if (hard_clr) begin
        rssi_q <= 3'h0;
      end else if (state_q == rdcu_pkg::RDCU_RSSI_RUN && !rx_dec_rst) begin
        rssi_q <= rssi_level; // [R17] [R19]
      end
    end
  end

  // Receiver decoder reset: block, enable, or TX end after wait [R20] [R21] [R22]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_dec_rst <= 1'b0;
    end else if (ce) begin
      if (hard_clr) begin
        rx_dec_rst <= 1'b0;
      end else if (cmd_go && cmd_code == `RDCU_C_RX_BLOCK) begin
        rx_dec_rst <= 1'b1; // [R20]
      end else if (cmd_go && cmd_code == `RDCU_C_RX_EN) begin
        rx_dec_rst <= 1'b0; // [R21]
      end else if (state_q == rdcu_pkg::RDCU_RX_WAIT && wait_q == '0) begin
        rx_dec_rst <= 1'b0; // [R21] [R22]
      end
    end
  end

  // Transmit strobes, byte output, slot marker and soft init pulse
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_start <= 1'b0;
      tx_crc <= 1'b0;
      tx_slot <= 1'b0;
      tx_byte_valid <= 1'b0;
      tx_byte <= 8'h00;
      soft_init <= 1'b0;
      coll_pos <= 7'h00;
    end else if (ce) begin
      tx_start <= (state_q == rdcu_pkg::RDCU_TX_ARM)
        && (delayed_q ? tx_timer_fire : (cnt_q != '0)); // [R8] [R10]
      tx_crc <= crc_q; // [R9]
      // Slot marker only with the vicinity protocol selected [R3] [R11]
      tx_slot <= cmd_go && cmd_code == `RDCU_C_SLOT && ctrl_q[`RDCU_CTRL_VIC_BIT];
      tx_byte_valid <= fifo_rd;
      if (tx_byte_valid) begin
        tx_byte <= mem_rdata;
      end
      soft_init <= init_go;
      coll_pos <= (fifo_rst_go || hard_clr) ? 7'h00 : collision_pos; // [R6]
    end
  end

  // APB read data and answer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      // Decoded in the setup phase so the word stands at the access edge
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `RDCU_OFF_CTRL: prdata <= {29'h0, ctrl_q};
          `RDCU_OFF_STAT: prdata <= {24'h0, 1'b0, ovf_q, cnt_q == '0,
                                     rx_dec_rst, gain_step, state_q != rdcu_pkg::RDCU_IDLE,
                                     1'b0} | {16'h0, 3'h0, cnt_q, 8'h00};
          `RDCU_OFF_RXWAIT: prdata <= {24'h0, rxwait_q};
          `RDCU_OFF_TXLEN: prdata <= {16'h0, txlen_q};
          `RDCU_OFF_RSSI: prdata <= {29'h0, rssi_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Assertions
  property p_unknown_nop;
    @(posedge mclk) disable iff (sys_rst)
      (ce && cmd_wr && !code_known(cmd_code) && state_q == rdcu_pkg::RDCU_IDLE && chip_en)
      |=> state_q == rdcu_pkg::RDCU_IDLE;
  endproperty
  a_unknown_nop: assert property (p_unknown_nop) else $error("unknown code acted"); // [R23]

  property p_block;
    @(posedge mclk) disable iff (sys_rst)
      (ce && chip_en && cmd_go && cmd_code == `RDCU_C_RX_BLOCK) |=> rx_dec_rst;
  endproperty
  a_block: assert property (p_block) else $error("block did not reset decoder"); // [R20]

  property p_enable;
    @(posedge mclk) disable iff (sys_rst)
      (ce && chip_en && !init_go && cmd_go && cmd_code == `RDCU_C_RX_EN) |=> !rx_dec_rst;
  endproperty
  a_enable: assert property (p_enable) else $error("enable did not release"); // [R21]

  property p_gain_limit;
    @(posedge mclk) disable iff (sys_rst) gain_step <= 2'(`RDCU_GAIN_STEPS);
  endproperty
  a_gain_limit: assert property (p_gain_limit) else $error("gain past limit"); // [R14]

  property p_gain_reset;
    @(posedge mclk) disable iff (sys_rst) (ce && !chip_en) |=> gain_step == 2'h0;
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain not restored"); // [R15]

  property p_fifo_clear;
    @(posedge mclk) disable iff (sys_rst) (ce && fifo_rst_go) |=> cnt_q == '0 && !ovf_q;
  endproperty
  a_fifo_clear: assert property (p_fifo_clear) else $error("fifo not cleared"); // [R6]

  property p_crc_kind;
    @(posedge mclk) disable iff (sys_rst)
      (ce && chip_en && !init_go && cmd_go && code_is_tx(cmd_code))
      |=> crc_q == $past(cmd_code[0]);
  endproperty
  a_crc_kind: assert property (p_crc_kind) else $error("crc variant wrong"); // [R9]

  sequence s_armed_delayed;
    ce && state_q == rdcu_pkg::RDCU_TX_ARM && delayed_q && !tx_timer_fire;
  endsequence
  property p_delay_hold;
    @(posedge mclk) disable iff (sys_rst) s_armed_delayed |=> !tx_start;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delayed tx early"); // [R10]

  property p_slot;
    @(posedge mclk) disable iff (sys_rst)
      (ce && tx_slot) |-> $past(ctrl_q[`RDCU_CTRL_VIC_BIT]);
  endproperty
  a_slot: assert property (p_slot) else $error("slot without vicinity"); // [R3]
endmodule
`default_nettype wire

// >>> testbench/rdcu_host_model.sv
// Host side model: APB master that issues register writes, reads and commands
`timescale 1ns/1ps
`default_nettype none
`include "rdcu_defines.svh"
module rdcu_host_model (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  // Bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer; entered just after a rising edge, leaves one idle cycle behind
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge mclk);
      penable <= 1'b1;
      // Hold the request until pready is seen high at an edge; the bench watchdog ends a hang
      do begin
        @(posedge mclk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data lines show the inverse of the last word
      pwdata <= ~d;
      @(posedge mclk);
    end
  endtask

  // Register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    begin
      xfer(1'b1, a, d, q);
    end
  endtask

  // Register read
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    begin
      xfer(1'b0, a, 32'h0000_0000, q);
    end
  endtask

  // Command word: flag bit set, code in the low five bits
  task automatic cmd(input logic [4:0] code);
    begin
      wr(`RDCU_OFF_CMD, {24'h000000, 3'h4, code});
    end
  endtask

  // Transmit sequence: command, then length, then payload bytes
  task automatic send(input logic [4:0] code, input logic [7:0] b0, input logic [7:0] b1);
    begin
      cmd(code);
      wr(`RDCU_OFF_TXLEN, 32'h0000_0002);
      wr(`RDCU_OFF_FIFO, {24'h000000, b0});
      wr(`RDCU_OFF_FIFO, {24'h000000, b1});
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/rdcu_top_test.sv
// Self-checking bench of the direct command unit
`timescale 1ns/1ps
`default_nettype none
`include "rdcu_defines.svh"
module rdcu_top_test;
  logic mclk, sys_rst, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic chip_en, tx_timer_fire, noisy;
  logic tx_ready = 1'b1, rx_digital = 1'b0;
  logic [2:0] rssi_level;
  logic [6:0] collision_pos, coll_pos;
  logic tx_start, tx_crc, tx_slot, tx_byte_valid, rx_dec_rst, soft_init;
  logic vld_d = 1'b0, crc_seen = 1'b0;
  logic [7:0] tx_byte;
  logic [1:0] gain_step;
  logic [7:0] got [$]; // Bytes seen on the transmit side
  logic [4:0] tx_codes [4] = '{5'h10, 5'h11, 5'h12, 5'h13};
  int n_mismatch = 0, checks_done = 0, n_start = 0, n_slot = 0, n_init = 0, w;

  // Clock of 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  rdcu_top #(.WIN_CYC(20), .DEPTH(12)) i_rdcu_top (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_en(chip_en),
    .tx_timer_fire(tx_timer_fire), .tx_ready(tx_ready), .rx_digital(rx_digital),
    .rssi_level(rssi_level), .collision_pos(collision_pos), .tx_start(tx_start),
    .tx_crc(tx_crc), .tx_slot(tx_slot), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
    .rx_dec_rst(rx_dec_rst), .gain_step(gain_step), .soft_init(soft_init), .coll_pos(coll_pos));

  rdcu_host_model i_rdcu_host_model (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

  // Transmit side and event monitor; tx_byte is valid the cycle after its strobe
  always @(posedge mclk) begin
    vld_d <= tx_byte_valid;
    if (vld_d === 1'b1) got.push_back(tx_byte);
    if (tx_byte_valid === 1'b1) crc_seen <= tx_crc;
    if (tx_start === 1'b1) n_start++;
    if (tx_slot === 1'b1) n_slot++;
    if (soft_init === 1'b1) n_init++;
    rx_digital <= noisy ? ~rx_digital : rx_digital;
    tx_ready <= noisy ? ~tx_ready : 1'b1;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp) begin
        n_mismatch++;
        $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask

  // Verdict and end of run
  task automatic close_out;
    begin
      $display("mismatches %0d, comparisons %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  // Watchdog at 50000 cycles, far beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1; ce = 1'b1; chip_en = 1'b1; tx_timer_fire = 1'b0;
    noisy = 1'b0; rssi_level = 3'h0; collision_pos = 7'h2a;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    check(gain_step, 2'h0);
    check(rx_dec_rst, 1'b0);
    @(posedge mclk);
    i_rdcu_host_model.rd(12'h0fc, q);
    check(q, 32'h0000_0000);
    check(pslverr, 1'b0);
    // Receiver block, idle and unknown codes keep it, enable releases it
    i_rdcu_host_model.cmd(5'h16);
    check(rx_dec_rst, 1'b1);
    i_rdcu_host_model.cmd(5'h00);
    i_rdcu_host_model.cmd(5'h01);
    i_rdcu_host_model.cmd(5'h1f);
    check(rx_dec_rst, 1'b1);
    i_rdcu_host_model.cmd(5'h17);
    check(rx_dec_rst, 1'b0);
    // Payload stays in the FIFO while idle; FIFO reset empties it
    i_rdcu_host_model.wr(`RDCU_OFF_FIFO, 32'h0000_0077);
    i_rdcu_host_model.rd(`RDCU_OFF_STAT, q);
    check(q[12:8], 5'h01);
    check(coll_pos, 7'h2a);
    i_rdcu_host_model.cmd(5'h0f);
    check(coll_pos, 7'h00);
    i_rdcu_host_model.rd(`RDCU_OFF_STAT, q);
    check({q[12:8], q[5]}, 6'h01);
    // All four transmit codes, decoder released only after the wait time
    i_rdcu_host_model.wr(`RDCU_OFF_RXWAIT, 32'h0000_0003);
    noisy <= 1'b1; // Transmitter ready only every other cycle
    for (int k = 0; k < 4; k++) begin
      got.delete();
      w = n_start;
      i_rdcu_host_model.cmd(5'h16);
      i_rdcu_host_model.send(tx_codes[k], 8'ha5 + k, 8'h3c);
      if (k >= 2) begin
        repeat (10) @(posedge mclk);
        check(n_start, w);
        tx_timer_fire <= 1'b1;
        @(posedge mclk);
        tx_timer_fire <= 1'b0;
      end
      for (int t = 0; t < 200 && got.size() < 2; t++) @(posedge mclk);
      check(n_start, w + 1);
      check(got.size(), 2);
      if (got.size() == 2) check({got[0], got[1]}, {8'ha5 + k, 8'h3c});
      check(crc_seen, k % 2);
      repeat (6) @(posedge mclk);
      check(rx_dec_rst, 1'b1);
      repeat (40) @(posedge mclk);
      check(rx_dec_rst, 1'b0);
    end
    noisy <= 1'b0;
    // Next slot only with the vicinity protocol selected
    i_rdcu_host_model.wr(`RDCU_OFF_CTRL, 32'h0000_0006);
    i_rdcu_host_model.cmd(5'h14);
    repeat (4) @(posedge mclk);
    check(n_slot, 0);
    i_rdcu_host_model.wr(`RDCU_OFF_CTRL, 32'h0000_0007);
    i_rdcu_host_model.cmd(5'h14);
    repeat (4) @(posedge mclk);
    check(n_slot, 1);
    // Gain adjust: quiet input keeps full gain, noise steps to the 15 dB limit
    i_rdcu_host_model.cmd(5'h1a);
    repeat (100) @(posedge mclk);
    check(gain_step, 2'h0);
    noisy <= 1'b1;
    i_rdcu_host_model.cmd(5'h1a);
    repeat (200) @(posedge mclk);
    check(gain_step, 2'h3);
    noisy <= 1'b0;
    i_rdcu_host_model.cmd(5'h03);
    @(posedge mclk);
    check(n_init, 1);
    check(gain_step, 2'h0);
    noisy <= 1'b1;
    i_rdcu_host_model.cmd(5'h1a);
    repeat (60) @(posedge mclk);
    check(gain_step >= 2'h2, 1'b1);
    noisy <= 1'b0;
    chip_en <= 1'b0;
    repeat (2) @(posedge mclk);
    check(gain_step, 2'h0);
    chip_en <= 1'b1;
    @(posedge mclk);
    // RF tests after the receiver is enabled, receiver on and output off first
    i_rdcu_host_model.wr(`RDCU_OFF_CTRL, 32'h0000_0002);
    i_rdcu_host_model.cmd(5'h17);
    rssi_level <= 3'h5;
    i_rdcu_host_model.cmd(5'h19);
    i_rdcu_host_model.rd(`RDCU_OFF_RSSI, q);
    check(q[2:0], 3'h5);
    i_rdcu_host_model.wr(`RDCU_OFF_CTRL, 32'h0000_0006);
    rssi_level <= 3'h7;
    i_rdcu_host_model.cmd(5'h18);
    i_rdcu_host_model.rd(`RDCU_OFF_RSSI, q);
    check(q[2:0], 3'h7);
    // A blocked receiver leaves the last level in place
    i_rdcu_host_model.cmd(5'h16);
    rssi_level <= 3'h2;
    i_rdcu_host_model.cmd(5'h18);
    i_rdcu_host_model.rd(`RDCU_OFF_RSSI, q);
    check(q[2:0], 3'h7);
    // Clock enable low freezes the gain search, which resumes afterwards
    noisy <= 1'b1;
    i_rdcu_host_model.cmd(5'h1a);
    ce <= 1'b0;
    repeat (100) @(posedge mclk);
    check(gain_step, 2'h0);
    ce <= 1'b1;
    repeat (30) @(posedge mclk);
    check(gain_step != 2'h0, 1'b1);
    noisy <= 1'b0;
    close_out();
  end
endmodule
`default_nettype wire
